//--- hdl/sac_sequencer.sv
// Sequencer for a 10-bit successive-approximation converter with APB access
// Function
// - Done flag sets at every conversion end, irrespective of irq enable
// - Hardware never clears done flag; software writes to clear it
// - With irq enabled and core asleep, completion raises a wake request
// - Justify 1: right, upper six high bits zero; 0: left, low six zero
// - Writing go bit 1 starts a conversion; converter on only at bit 0
// - Completion clears go, sets done flag and loads both result bytes
// - Go cleared mid-conversion stores partial result, unresolved bits copy
// - Reset returns registers to reset values and ends any conversion
// - RC clock selected: start delayed one extra instruction cycle
// - Sleep, RC clock, irq off: power down after completion, on reads 1
// - Sleep with system-derived clock aborts and powers down, on reads 1
// - Rising edge of selected trigger source sets go by hardware
// - Trigger select decode: none, reserved, timers, comparators
// - Channel decode: inputs 3 to 11, temperature, DAC, reference buffer
// - Clock decode: system divided by 2..64, or dedicated RC clock
// - Reference decode: supply, external pin, fixed reference; 01 reserved
// - Go reads 1 while converting, 0 otherwise
// - Converter off when converter_on is 0, drawing no current
// - Unimplemented control bits read zero
// - Left format: result bits 9..2 fill the high byte
// - Left: bits 1..0 at low 7..6; right: bits 9..8 at high 1..0
// - Full conversion takes one lead period plus eleven conversion clock periods
`timescale 1ns/1ps
module sac_sequencer (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Core and system
  input wire logic SLEEP,
  input wire logic INSTR_TICK,
  input wire logic RC_TICK,
  // Trigger sources
  input wire logic TIMER_ZERO_OVF,
  input wire logic TIMER_ONE_OVF,
  input wire logic TIMER_TWO_MATCH,
  input wire logic CMP1_SYNC,
  input wire logic CMP2_SYNC,
  // Analog interface
  input wire logic CMP_OUT,
  output logic [9:0] DAC_CODE,
  output logic ANA_POWER,
  output logic SAMPLE_HOLD,
  output logic [11:0] CHANNEL_ONEHOT,
  output logic [2:0] REF_ONEHOT,
  // Events
  output logic DONE_FLAG,
  output logic WAKE_REQ
);
  // ---------------------------------------------------------------
  // Decode functions
  // ---------------------------------------------------------------
  // Divider exponent for the clock select, 0 means RC clock
  function automatic logic [2:0] div_exp(input logic [2:0] cks);
    unique case (cks)
      3'h0: div_exp = 3'h1;
      3'h4: div_exp = 3'h2;
      3'h1: div_exp = 3'h3;
      3'h5: div_exp = 3'h4;
      3'h2: div_exp = 3'h5;
      3'h6: div_exp = 3'h6;
      default: div_exp = 3'h0;
    endcase
  endfunction

  function automatic logic is_rc(input logic [7:0] c1);
    is_rc = c1[sac_pkg::CKS_LSB +: 2] == 2'h3;
  endfunction

  // Copy the last resolved bit into every unresolved position
  function automatic logic [9:0] fill_partial(input logic [9:0] s,
                                              input logic [3:0] idx);
    logic [9:0] r;
    r = s;
    for (int i = 0; i < sac_pkg::RES_BITS; i++) begin
      if (i <= 32'(idx)) begin
        r[i] = (idx == 4'h9) ? 1'b0 : s[idx + 4'h1];
      end
    end
    if (idx == 4'h9) begin
      r[9] = 1'b0;
    end
    fill_partial = r;
  endfunction

  function automatic sac_pkg::sac_result_s fmt(input logic [9:0] v,
                                               input logic rj);
    sac_pkg::sac_result_s o;
    if (rj) begin
      o.high = {6'h00, v[9:8]};
      o.low = v[7:0];
    end else begin
      o.high = v[9:2];
      o.low = {v[1:0], 6'h00};
    end
    fmt = o;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sac_pkg::sac_state_s s, next_s;
  logic [4:0] trg_in;
  logic trg_edge, conv_tick, wr, rd, rc_sel, going, done_evt;
  logic [6:0] div_lim;

  assign trg_in = {CMP2_SYNC, CMP1_SYNC, TIMER_TWO_MATCH, TIMER_ONE_OVF, TIMER_ZERO_OVF};
  assign rc_sel = is_rc(s.ctrl1);
  assign div_lim = 7'((8'h01 << div_exp(s.ctrl1[sac_pkg::CKS_LSB +: 3])) - 8'h01);
  assign conv_tick = rc_sel ? RC_TICK : (s.div_cnt == div_lim);
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PWRITE;
  assign going = s.st != sac_pkg::SAC_IDLE;

  always_comb begin
    trg_edge = 1'b0;
    unique case (s.ctrl2[sac_pkg::TRG_LSB +: 3])
      sac_pkg::TRG_TIMER_ZERO: trg_edge = trg_in[0] && !s.trg_prev[0];
      sac_pkg::TRG_TIMER_ONE: trg_edge = trg_in[1] && !s.trg_prev[1];
      sac_pkg::TRG_TIMER_TWO: trg_edge = trg_in[2] && !s.trg_prev[2];
      sac_pkg::TRG_CMP1: trg_edge = trg_in[3] && !s.trg_prev[3];
      sac_pkg::TRG_CMP2: trg_edge = trg_in[4] && !s.trg_prev[4];
      default: trg_edge = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [9:0] trial;
    trial = '0;
    next_s = s;
    done_evt = 1'b0;
    next_s.trg_prev = trg_in;
    next_s.div_cnt = (conv_tick || !going) ? 7'h00 : s.div_cnt + 7'h01;
    if (!SLEEP) begin
      next_s.pd = 1'b0;
    end
    // Register writes
    if (wr) begin
      unique case (PADDR)
        sac_pkg::ADDR_CTRL0: begin
          next_s.ctrl0 = PWDATA[7:0] & sac_pkg::CTRL0_MASK;
        end
        sac_pkg::ADDR_CTRL1: begin
          next_s.ctrl1 = PWDATA[7:0] & sac_pkg::CTRL1_MASK;
        end
        sac_pkg::ADDR_CTRL2: begin
          next_s.ctrl2 = PWDATA[7:0] & sac_pkg::CTRL2_MASK;
        end
        sac_pkg::ADDR_RESH: next_s.res.high = PWDATA[7:0];
        sac_pkg::ADDR_RESL: next_s.res.low = PWDATA[7:0];
        sac_pkg::ADDR_STAT: begin
          if (!PWDATA[sac_pkg::DONE_BIT]) begin
            next_s.done = 1'b0;
          end
          next_s.ien = PWDATA[sac_pkg::IEN_BIT];
        end
        default: ;
      endcase
    end
    if (trg_edge && s.ctrl0[sac_pkg::ON_BIT]) begin
      next_s.ctrl0[sac_pkg::GO_BIT] = 1'b1;
    end
    // Sequencer
    unique case (s.st)
      sac_pkg::SAC_IDLE: begin
        if (next_s.ctrl0[sac_pkg::GO_BIT] && s.ctrl0[sac_pkg::ON_BIT]) begin
          next_s.sar = 10'h200;
          next_s.bit_idx = 4'h9;
          next_s.per_cnt = 4'h0;
          next_s.st = rc_sel ? sac_pkg::SAC_DELAY : sac_pkg::SAC_LEAD;
        end else if (!s.ctrl0[sac_pkg::ON_BIT]) begin
          next_s.ctrl0[sac_pkg::GO_BIT] = 1'b0;
        end
      end
      sac_pkg::SAC_DELAY: begin
        if (INSTR_TICK) begin
          next_s.st = sac_pkg::SAC_LEAD;
        end
      end
      sac_pkg::SAC_LEAD: begin
        if (conv_tick) begin
          next_s.st = sac_pkg::SAC_CONV;
        end
      end
      sac_pkg::SAC_CONV: begin
        if (conv_tick) begin
          next_s.per_cnt = s.per_cnt + 4'h1;
          if (s.per_cnt < 4'(sac_pkg::RES_BITS)) begin
            trial = s.sar;
            trial[s.bit_idx] = CMP_OUT;
            if (s.bit_idx != 4'h0) begin
              trial[s.bit_idx - 4'h1] = 1'b1;
              next_s.bit_idx = s.bit_idx - 4'h1;
            end
            next_s.sar = trial;
          end
          if (s.per_cnt + 4'h1 == sac_pkg::CONV_PERIODS) begin
            next_s.st = sac_pkg::SAC_IDLE;
            next_s.res = fmt(s.sar, s.ctrl1[sac_pkg::JUST_BIT]);
            next_s.ctrl0[sac_pkg::GO_BIT] = 1'b0;
            done_evt = 1'b1;
            if (SLEEP && !s.ien) begin
              next_s.pd = 1'b1;
            end
          end
        end
      end
      default: next_s.st = sac_pkg::SAC_IDLE;
    endcase
    // Software abort keeps a partial result
    if (going && wr && PADDR == sac_pkg::ADDR_CTRL0
        && !PWDATA[sac_pkg::GO_BIT] && !done_evt) begin
      next_s.st = sac_pkg::SAC_IDLE;
      next_s.res = fmt(fill_partial(s.sar, s.bit_idx),
                       s.ctrl1[sac_pkg::JUST_BIT]);
    end
    // Sleep with system clock aborts without a result
    if (going && SLEEP && !rc_sel) begin
      next_s.st = sac_pkg::SAC_IDLE;
      next_s.ctrl0[sac_pkg::GO_BIT] = 1'b0;
      next_s.pd = 1'b1;
    end
    if (!next_s.ctrl0[sac_pkg::ON_BIT]) begin
      next_s.st = sac_pkg::SAC_IDLE;
    end
    if (done_evt) begin
      next_s.done = 1'b1;
    end
    // Read data latched in the setup cycle
    next_s.prdata = 8'h00;
    if (rd) begin
      unique case (PADDR)
        sac_pkg::ADDR_CTRL0: next_s.prdata = s.ctrl0;
        sac_pkg::ADDR_CTRL1: next_s.prdata = s.ctrl1;
        sac_pkg::ADDR_CTRL2: next_s.prdata = s.ctrl2;
        sac_pkg::ADDR_RESH: next_s.prdata = s.res.high;
        sac_pkg::ADDR_RESL: next_s.prdata = s.res.low;
        sac_pkg::ADDR_STAT: next_s.prdata = {6'h00, s.ien, s.done};
        default: next_s.prdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s <= '{st: sac_pkg::SAC_IDLE, ctrl0: sac_pkg::CTRL_RST,
             ctrl1: sac_pkg::CTRL_RST, ctrl2: sac_pkg::CTRL_RST,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic legal;
  always_comb begin
    legal = 1'b1;
    unique case (PADDR)
      sac_pkg::ADDR_CTRL0, sac_pkg::ADDR_CTRL1, sac_pkg::ADDR_CTRL2,
      sac_pkg::ADDR_RESH, sac_pkg::ADDR_RESL, sac_pkg::ADDR_STAT: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !legal;
  assign PRDATA = {24'h000000, s.prdata};
  assign DAC_CODE = s.sar;
  assign ANA_POWER = s.ctrl0[sac_pkg::ON_BIT] && !s.pd;
  assign SAMPLE_HOLD = s.st == sac_pkg::SAC_LEAD || s.st == sac_pkg::SAC_CONV;
  assign DONE_FLAG = s.done;
  assign WAKE_REQ = s.done && s.ien && SLEEP;

  always_comb begin
    logic [4:0] ch;
    ch = s.ctrl0[sac_pkg::CHS_LSB +: 5];
    CHANNEL_ONEHOT = 12'h000;
    if (ch >= sac_pkg::CH_EXT_LO && ch <= sac_pkg::CH_EXT_HI) begin
      CHANNEL_ONEHOT = 12'(12'h001 << (ch - sac_pkg::CH_EXT_LO));
    end else if (ch == sac_pkg::CH_TEMP) begin
      CHANNEL_ONEHOT = 12'h200;
    end else if (ch == sac_pkg::CH_DAC) begin
      CHANNEL_ONEHOT = 12'h400;
    end else if (ch == sac_pkg::CH_FVR) begin
      CHANNEL_ONEHOT = 12'h800;
    end
  end

  always_comb begin
    unique case (s.ctrl1[1:0])
      sac_pkg::REF_VDD: REF_ONEHOT = 3'h1;
      sac_pkg::REF_PIN: REF_ONEHOT = 3'h2;
      sac_pkg::REF_FVR: REF_ONEHOT = 3'h4;
      default: REF_ONEHOT = 3'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  sequence conv_step;
    s.st == sac_pkg::SAC_CONV && conv_tick && s.bit_idx != 4'h0;
  endsequence

  done_sets_a: assert property (
    done_evt |=> s.done)
    else $error("done flag not set at completion");
  done_sticky_a: assert property (
    s.done && !(wr && PADDR == sac_pkg::ADDR_STAT) |=> s.done)
    else $error("done flag cleared by hardware");
  wake_req_a: assert property (
    s.done && s.ien && SLEEP |-> WAKE_REQ)
    else $error("no wake request");
  right_just_a: assert property (
    done_evt && s.ctrl1[sac_pkg::JUST_BIT] |=> s.res.high[7:2] == 6'h00)
    else $error("right justified upper bits not zero");
  left_just_a: assert property (
    done_evt && !s.ctrl1[sac_pkg::JUST_BIT] |=> s.res.low[5:0] == 6'h00)
    else $error("left justified lower bits not zero");
  go_clear_a: assert property (
    done_evt |=> !s.ctrl0[sac_pkg::GO_BIT])
    else $error("go not cleared at completion");
  abort_idle_a: assert property (
    going && wr && PADDR == sac_pkg::ADDR_CTRL0
    && !PWDATA[sac_pkg::GO_BIT] |=> s.st == sac_pkg::SAC_IDLE)
    else $error("software abort ignored");
  reset_clear_a: assert property (
    disable iff (1'b0)
    !NRST |=> s.st == sac_pkg::SAC_IDLE && s.ctrl0 == sac_pkg::CTRL_RST)
    else $error("reset left state behind");
  rc_delay_a: assert property (
    s.st == sac_pkg::SAC_IDLE && next_s.st != sac_pkg::SAC_IDLE && rc_sel
    |=> s.st == sac_pkg::SAC_DELAY)
    else $error("rc start not delayed");
  sleep_off_a: assert property (
    done_evt && SLEEP && !s.ien |=> !ANA_POWER)
    else $error("converter powered after sleep completion");
  sleep_abort_a: assert property (
    going && SLEEP && !rc_sel |=> s.st == sac_pkg::SAC_IDLE && s.pd)
    else $error("sleep did not abort");
  trig_go_a: assert property (
    trg_edge && s.ctrl0[sac_pkg::ON_BIT] && !going
    |=> s.ctrl0[sac_pkg::GO_BIT])
    else $error("trigger did not set go");
  go_busy_a: assert property (
    going |-> s.ctrl0[sac_pkg::GO_BIT])
    else $error("go low during conversion");
  off_idle_a: assert property (
    !s.ctrl0[sac_pkg::ON_BIT] |-> !ANA_POWER && !SAMPLE_HOLD)
    else $error("converter active while off");
  unimpl_zero_a: assert property (
    s.ctrl0[7] == 1'b0 && s.ctrl2[3:0] == 4'h0 && s.ctrl2[7] == 1'b0)
    else $error("unimplemented bits set");
  conv_len_a: assert property (
    done_evt |-> s.st == sac_pkg::SAC_CONV && s.bit_idx == 4'h0)
    else $error("completion before all bits resolved");
  bit_step_a: assert property (
    conv_step |=> s.bit_idx == $past(s.bit_idx) - 4'h1)
    else $error("bit order broken");
  bit_hold_a: assert property (
    s.st == sac_pkg::SAC_CONV && !conv_tick |=> $stable(s.bit_idx))
    else $error("bit resolved without conversion clock");
endmodule // sac_sequencer

//--- inc/sac_pkg.sv
// Package: register map, field layout, encodings and timing for the sequencer
package sac_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_RESH = 8'h0c;
  localparam logic [7:0] ADDR_RESL = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int ON_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHS_LSB = 2;
  localparam int JUST_BIT = 7;
  localparam int CKS_LSB = 4;
  localparam int TRG_LSB = 4;
  localparam int DONE_BIT = 0;
  localparam int IEN_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL0_MASK = 8'h7f;
  localparam logic [7:0] CTRL1_MASK = 8'hf3;
  localparam logic [7:0] CTRL2_MASK = 8'h70;
  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] TRG_TIMER_ZERO = 3'h3;
  localparam logic [2:0] TRG_TIMER_ONE = 3'h4;
  localparam logic [2:0] TRG_TIMER_TWO = 3'h5;
  localparam logic [2:0] TRG_CMP1 = 3'h6;
  localparam logic [2:0] TRG_CMP2 = 3'h7;
  localparam logic [4:0] CH_EXT_LO = 5'h03;
  localparam logic [4:0] CH_EXT_HI = 5'h0b;
  localparam logic [4:0] CH_TEMP = 5'h1d;
  localparam logic [4:0] CH_DAC = 5'h1e;
  localparam logic [4:0] CH_FVR = 5'h1f;
  localparam logic [1:0] REF_VDD = 2'h0;
  localparam logic [1:0] REF_PIN = 2'h2;
  localparam logic [1:0] REF_FVR = 2'h3;
  // ---------------------------------------------------------------
  // Timing: 1 lead period, ending at the next conversion tick, plus 11 whole periods
  // ---------------------------------------------------------------
  localparam int RES_BITS = 10;
  localparam logic [3:0] CONV_PERIODS = 4'hb;
  localparam logic [3:0] RC_START_DELAY = 4'h1;
  typedef enum logic [3:0] {
    SAC_IDLE = 4'b0001,
    SAC_DELAY = 4'b0010,
    SAC_LEAD = 4'b0100,
    SAC_CONV = 4'b1000
  } sac_state_e;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } sac_result_s;
  typedef struct packed {
    sac_state_e st;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    sac_result_s res;
    logic done;
    logic ien;
    logic [9:0] sar;
    logic [3:0] bit_idx;
    logic [3:0] per_cnt;
    logic [6:0] div_cnt;
    logic [4:0] trg_prev;
    logic pd;
    logic [7:0] prdata;
  } sac_state_s;
endpackage

//--- verification/sac_sequencer_tb_top.sv
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t %s got %0h exp %0h", $time, m, g, e); end end
module sac_sequencer_tb_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic SLEEP = 1'b0;
  logic INSTR_TICK = 1'b0;
  logic RC_TICK = 1'b0;
  logic CMP_OUT = 1'b0;
  logic [4:0] trg = 5'h00;
  logic [9:0] vin = 10'h000;
  logic rc_run = 1'b1;
  logic it_run = 1'b1;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, ANA_POWER, SAMPLE_HOLD, DONE_FLAG, WAKE_REQ;
  logic [9:0] DAC_CODE;
  logic [11:0] CHANNEL_ONEHOT;
  logic [2:0] REF_ONEHOT;
  int cyc = 0;
  int n_errors = 0;
  int checked = 0;

  sac_sequencer sac_sequencer_i (
    .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP(SLEEP),
    .INSTR_TICK(INSTR_TICK), .RC_TICK(RC_TICK), .TIMER_ZERO_OVF(trg[0]),
    .TIMER_ONE_OVF(trg[1]), .TIMER_TWO_MATCH(trg[2]), .CMP1_SYNC(trg[3]),
    .CMP2_SYNC(trg[4]), .CMP_OUT(CMP_OUT), .DAC_CODE(DAC_CODE),
    .ANA_POWER(ANA_POWER), .SAMPLE_HOLD(SAMPLE_HOLD),
    .CHANNEL_ONEHOT(CHANNEL_ONEHOT), .REF_ONEHOT(REF_ONEHOT),
    .DONE_FLAG(DONE_FLAG), .WAKE_REQ(WAKE_REQ));

  // ---------------------------------------------------------------
  // Clock, ticks and comparator model
  // ---------------------------------------------------------------
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    RC_TICK <= rc_run && (cyc % 7 == 0);
    INSTR_TICK <= it_run && (cyc % 4 == 0);
    CMP_OUT <= (DAC_CODE <= vin);
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] x, string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    `CHK(r, {24'h0, x}, m)
  endtask
  task automatic wait_done(input int lim, output int n);
    n = 0;
    while (DONE_FLAG !== 1'b1 && n < lim) begin
      @(posedge CLK);
      n++;
    end
  endtask
  function automatic logic [11:0] ch_hot(input int c);
    ch_hot = 12'h000;
    if (c >= 3 && c <= 11) ch_hot[c-3] = 1'b1;
    else if (c >= 29) ch_hot[c-20] = 1'b1;
  endfunction
  task automatic go_conv(input logic [7:0] c1);
    wr(sac_pkg::ADDR_CTRL1, c1);
    wr(sac_pkg::ADDR_CTRL0, 8'h0d);
    wr(sac_pkg::ADDR_CTRL0, 8'h0f);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    chk_rd(sac_pkg::ADDR_CTRL0, 8'h00, "ctrl0 reset");
    chk_rd(sac_pkg::ADDR_CTRL1, 8'h00, "ctrl1 reset");
    chk_rd(sac_pkg::ADDR_CTRL2, 8'h00, "ctrl2 reset");
    chk_rd(sac_pkg::ADDR_STAT, 8'h00, "stat reset");
    wr(sac_pkg::ADDR_CTRL0, 8'hfd);
    wr(sac_pkg::ADDR_CTRL1, 8'hff);
    wr(sac_pkg::ADDR_CTRL2, 8'hff);
    chk_rd(sac_pkg::ADDR_CTRL0, 8'h7d, "ctrl0 mask");
    chk_rd(sac_pkg::ADDR_CTRL1, 8'hf3, "ctrl1 mask");
    chk_rd(sac_pkg::ADDR_CTRL2, 8'h70, "ctrl2 mask");
    apb(1'b0, 8'h18, 8'h00, r, e);
    `CHK({r, e}, {32'h0, 1'b1}, "unmapped read")
    wr(sac_pkg::ADDR_CTRL2, 8'h00);
    wr(sac_pkg::ADDR_CTRL0, 8'h00);
    @(posedge CLK);
    `CHK(ANA_POWER, 1'b0, "power when off")
  endtask
  task automatic t_decode();
    logic [2:0] rx;
    for (int c = 0; c < 32; c++) begin
      wr(sac_pkg::ADDR_CTRL0, {1'b0, c[4:0], 2'b01});
      @(posedge CLK);
      `CHK(CHANNEL_ONEHOT, ch_hot(c), "channel")
    end
    `CHK(ANA_POWER, 1'b1, "power when on")
    for (int p = 0; p < 4; p++) begin
      rx = (p == 0) ? 3'h1 : (p == 2) ? 3'h2 : (p == 3) ? 3'h4 : 3'h0;
      wr(sac_pkg::ADDR_CTRL1, {6'h00, p[1:0]});
      @(posedge CLK);
      `CHK(REF_ONEHOT, rx, "reference")
    end
  endtask
  task automatic t_conv();
    logic [2:0] codes [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    logic [15:0] x;
    int n;
    int dv;
    for (int i = 0; i < 6; i++) begin
      dv = 2 << i;
      vin = 10'h2a5 + 10'(i * 73);
      x = i[0] ? {6'h00, vin} : {vin, 6'h00};
      wr(sac_pkg::ADDR_STAT, 8'h00);
      go_conv({i[0], codes[i], 4'h0});
      chk_rd(sac_pkg::ADDR_CTRL0, 8'h0f, "busy mid");
      `CHK(SAMPLE_HOLD, 1'b1, "sampling")
      wait_done(12 * dv + 20, n);
      `CHK(n >= 11 * dv - 4 && n <= 12 * dv + 3, 1'b1, "conv time")
      chk_rd(sac_pkg::ADDR_CTRL0, 8'h0d, "go clear");
      `CHK(SAMPLE_HOLD, 1'b0, "sample end")
      chk_rd(sac_pkg::ADDR_RESH, x[15:8], "res high");
      chk_rd(sac_pkg::ADDR_RESL, x[7:0], "res low");
      chk_rd(sac_pkg::ADDR_STAT, 8'h01, "done set");
      repeat (40) @(posedge CLK);
      `CHK(DONE_FLAG, 1'b1, "done sticky")
      wr(sac_pkg::ADDR_STAT, 8'h00);
      @(posedge CLK);
      `CHK(DONE_FLAG, 1'b0, "done clear")
    end
  endtask
  task automatic t_abort();
    // Last resolved bit 0, so the pending trial bit must be filled too
    vin = 10'h200;
    go_conv(8'h60);
    repeat (400) @(posedge CLK);
    wr(sac_pkg::ADDR_CTRL0, 8'h0d);
    repeat (2) @(posedge CLK);
    chk_rd(sac_pkg::ADDR_CTRL0, 8'h0d, "abort go");
    chk_rd(sac_pkg::ADDR_RESH, 8'h80, "partial high");
    chk_rd(sac_pkg::ADDR_RESL, 8'h00, "partial low");
  endtask
  task automatic t_rc();
    int n;
    vin = 10'h155;
    it_run = 1'b0;
    wr(sac_pkg::ADDR_STAT, 8'h00);
    go_conv(8'hb0);
    repeat (200) @(posedge CLK);
    `CHK(DONE_FLAG, 1'b0, "rc waits instr")
    it_run = 1'b1;
    wait_done(400, n);
    `CHK(n < 400, 1'b1, "rc done")
    chk_rd(sac_pkg::ADDR_RESL, 8'h55, "rc low");
    wr(sac_pkg::ADDR_STAT, 8'h00);
    go_conv(8'hf0);
    SLEEP <= 1'b1;
    wait_done(400, n);
    repeat (2) @(posedge CLK);
    `CHK({ANA_POWER, WAKE_REQ}, 2'b00, "sleep power down")
    chk_rd(sac_pkg::ADDR_CTRL0, 8'h0d, "on stays");
    SLEEP <= 1'b0;
    wr(sac_pkg::ADDR_STAT, 8'h02);
    wr(sac_pkg::ADDR_CTRL0, 8'h0f);
    SLEEP <= 1'b1;
    wait_done(400, n);
    @(posedge CLK);
    `CHK(WAKE_REQ, 1'b1, "wake")
    SLEEP <= 1'b0;
    wr(sac_pkg::ADDR_STAT, 8'h00);
  endtask
  task automatic t_sleep_abort();
    go_conv(8'h60);
    repeat (100) @(posedge CLK);
    SLEEP <= 1'b1;
    repeat (3) @(posedge CLK);
    `CHK({ANA_POWER, DONE_FLAG}, 2'b00, "sleep abort")
    chk_rd(sac_pkg::ADDR_CTRL0, 8'h0d, "sleep go clear");
    SLEEP <= 1'b0;
  endtask
  task automatic t_trig();
    int n;
    wr(sac_pkg::ADDR_CTRL1, 8'h80);
    wr(sac_pkg::ADDR_CTRL0, 8'h0d);
    for (int s = 0; s < 3; s++) begin
      wr(sac_pkg::ADDR_CTRL2, {1'b0, s[2:0], 4'h0});
      trg <= 5'h1f;
      repeat (60) @(posedge CLK);
      `CHK(DONE_FLAG, 1'b0, "no trigger")
      trg <= 5'h00;
    end
    for (int s = 3; s < 8; s++) begin
      wr(sac_pkg::ADDR_CTRL2, {1'b0, s[2:0], 4'h0});
      @(posedge CLK);
      trg[s-3] <= 1'b1;
      wait_done(60, n);
      `CHK(n < 60, 1'b1, "trigger start")
      trg <= 5'h00;
      wr(sac_pkg::ADDR_STAT, 8'h00);
    end
  endtask
  task automatic t_reset_mid();
    go_conv(8'h60);
    repeat (100) @(posedge CLK);
    NRST <= 1'b0;
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    chk_rd(sac_pkg::ADDR_CTRL0, 8'h00, "reset ctrl0");
    chk_rd(sac_pkg::ADDR_CTRL1, 8'h00, "reset ctrl1");
    repeat (900) @(posedge CLK);
    `CHK({DONE_FLAG, ANA_POWER}, 2'b00, "reset ends")
  endtask

  // ---------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    t_regs();
    t_decode();
    t_conv();
    t_abort();
    t_rc();
    t_sleep_abort();
    t_trig();
    t_reset_mid();
    report_and_stop();
  end
  initial begin
    #400us;
    n_errors++;
    report_and_stop();
  end
endmodule // sac_sequencer_tb_top
